/* File: shared/rsc_pkg.sv */
// Purpose: constants, states and carriers of the resonant controller sequencer
// Assumes: clk runs at 125 MHz
// Notes: APB registers take one aligned 32-bit word each
`default_nettype none

package rsc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_MHZ = 125;
  localparam int unsigned VCC_BLANK_US = 20;
  localparam int unsigned OT_BLANK_US = 20;
  localparam int unsigned START_PHASE_US = 50;
  localparam int unsigned SOFT_START_US = 500;
  localparam int unsigned AUTO_RECOVERY_US = 1000000;
  localparam int unsigned VCC_BLANK_CYC = VCC_BLANK_US * CLK_FREQ_MHZ;
  localparam int unsigned OT_BLANK_CYC = OT_BLANK_US * CLK_FREQ_MHZ;
  localparam int unsigned START_PHASE_CYC = START_PHASE_US * CLK_FREQ_MHZ;
  localparam int unsigned SOFT_START_CYC = SOFT_START_US * CLK_FREQ_MHZ;
  localparam int unsigned AUTO_RECOVERY_CYC = AUTO_RECOVERY_US * CLK_FREQ_MHZ;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int unsigned CTRL_PERMIT_POS = 0;
  localparam logic CTRL_PERMIT_RESET = 1'b1;
  localparam int unsigned STATUS_STATE_POS = 0;
  localparam int unsigned STATUS_REASON_POS = 4;
  localparam int unsigned STATUS_OUT_POS = 8;
  localparam int unsigned STATUS_CMP_POS = 16;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    RSC_OFF = 4'h0,
    RSC_CHARGE = 4'h1,
    RSC_BLANK = 4'h2,
    RSC_START = 4'h3,
    RSC_SOFT = 4'h4,
    RSC_RUN = 4'h5,
    RSC_SKIP = 4'h6,
    RSC_WAIT = 4'h7,
    RSC_RECOVER = 4'h8,
    RSC_LATCH = 4'h9
  } rscState_e;

  typedef enum logic [1:0] {
    RSC_WAIT_BULK = 2'h0,
    RSC_WAIT_VOLT = 2'h1,
    RSC_WAIT_SKIP = 2'h2,
    RSC_WAIT_SOFTWARE = 2'h3
  } rscReason_e;

  typedef struct packed {
    logic supplyOn;
    logic supplyOff;
    logic supplyReset;
    logic bulkGood;
    logic skipIn;
    logic skipOut;
    logic overload;
    logic overVolt;
    logic overTemp;
  } rscCmp_s;

  typedef struct packed {
    logic undervoltageMonitor;
    logic feedbackLoop;
    logic protect;
    logic frontStage;
    logic core;
  } rscBias_s;

endpackage : rsc_pkg

`default_nettype wire

/* File: design/rsc_sequencer.sv */
// Purpose: operating-state sequencer of a half-bridge resonant controller
// Assumes: comparator levels arrive asynchronously; APB slave with zero wait states
// Notes: one clock; all outputs registered except the APB handshake
//
// What this block does
// - feedback below skip entry after first supply-on withholds startup like a brown-out.
// - overload stops switching; only the feedback loop stays biased.
// - after overload stop, startup source runs in dynamic self-supply mode.
// - after overload stop, a recovery timer counts the fixed auto-recovery delay.
// - when recovery delay expires, the startup current source recharges the supply.
// - clean restart runs a startup phase then a soft-start phase.
// - first supply-on biases monitor, feedback, protection, front-stage; mode output closes divider.
// - every supply-on starts a blanking period ignoring all fault inputs.
// - overvoltage present at blanking end keeps gate drivers disabled.
// - once blocking overvoltage clears, startup source recharges for a new attempt.
// - gate drivers authorised when blanking ends with no fault present.
// - at skip threshold only feedback and supply management stay on, no pulses.
// - at skip exit all blocks and gate drivers re-enabled for a burst.
// - during skip bursts the startup source stays off.
// - each skip burst starts an overtemperature blanking period.
// - supply below the off threshold in skip mode enters off-mode.
// - brown-out during burst disables drivers and protection, self-supply, waits bulk good.
// - while waiting after brown-out the front-stage mode output stays on.
// - after bulk good and supply-on, both blankings start then full startup.
// - over-limit input in operation latches off, feedback only, self-supply holds supply.
// - latched-off state clears only when supply falls below reset threshold.
`timescale 1ns/1ps
`default_nettype none

module rsc_sequencer #(
  parameter int unsigned CW = 28,
  parameter int unsigned VCC_BLANK = rsc_pkg::VCC_BLANK_CYC,
  parameter int unsigned OT_BLANK = rsc_pkg::OT_BLANK_CYC,
  parameter int unsigned START_PHASE = rsc_pkg::START_PHASE_CYC,
  parameter int unsigned SOFT_START = rsc_pkg::SOFT_START_CYC,
  parameter int unsigned AUTO_RECOVERY = rsc_pkg::AUTO_RECOVERY_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire rsc_pkg::rscCmp_s cmpIn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output rsc_pkg::rscBias_s biasEnable,
  output logic gateDriveOutputs,
  output logic startupSourceOn,
  output logic dynamicSelfSupply,
  output logic frontStageModeOutput
);
  import rsc_pkg::*;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  generate
    if (VCC_BLANK < 1 || OT_BLANK < 1 || START_PHASE < 1 || SOFT_START < 1
        || AUTO_RECOVERY < 1) begin : g_badMin
      $error("rsc_sequencer: every duration must be at least one cycle");
    end
    if (CW < 2 || CW > 31 || AUTO_RECOVERY >= (1 << CW) || VCC_BLANK >= (1 << CW)
        || SOFT_START >= (1 << CW) || START_PHASE >= (1 << CW)
        || OT_BLANK >= (1 << CW)) begin : g_badWidth
      $error("rsc_sequencer: counter width too small for a duration");
    end
  endgenerate

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  rscCmp_s cmpMeta_q;
  rscCmp_s cmp_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmpMeta_q <= '0;
      cmp_q <= '0;
    end else begin
      cmpMeta_q <= cmpIn;
      cmp_q <= cmpMeta_q;
    end
  end

  // ----------------------------------------
  // state and counters
  // ----------------------------------------
  rscState_e state_q;
  rscState_e state_d;
  rscReason_e reason_q;
  rscReason_e reason_d;
  logic [CW-1:0] phaseCnt_q;
  logic [CW-1:0] otCnt_q;
  logic permit_q;

  wire phaseDone = (phaseCnt_q == '0);
  wire otMask = (otCnt_q != '0);
  wire activeRun = (state_q == RSC_START) || (state_q == RSC_SOFT) || (state_q == RSC_RUN);
  wire limitFault = cmp_q.overVolt || (cmp_q.overTemp && !otMask);
  wire stateChange = (state_d != state_q);
  wire otStart = (state_d == RSC_BLANK && state_q != RSC_BLANK)
                 || (state_q == RSC_SKIP && state_d == RSC_RUN);
  wire [CW-1:0] phaseLoad = (state_d == RSC_BLANK) ? CW'(VCC_BLANK - 1) :
                            (state_d == RSC_START) ? CW'(START_PHASE - 1) :
                            (state_d == RSC_SOFT) ? CW'(SOFT_START - 1) :
                            (state_d == RSC_RECOVER) ? CW'(AUTO_RECOVERY - 1) : '0;

  always_comb begin
    state_d = state_q;
    reason_d = reason_q;
    unique case (state_q)
      RSC_OFF, RSC_CHARGE: begin
        if (cmp_q.supplyOn) begin
          state_d = RSC_BLANK;
        end
      end
      RSC_BLANK: begin
        if (phaseDone) begin
          if (cmp_q.overVolt) begin
            state_d = RSC_WAIT;
            reason_d = RSC_WAIT_VOLT;
          end else if (!cmp_q.bulkGood) begin
            state_d = RSC_WAIT;
            reason_d = RSC_WAIT_BULK;
          end else if (cmp_q.skipIn) begin
            state_d = RSC_WAIT;
            reason_d = RSC_WAIT_SKIP;
          end else if (!permit_q) begin
            state_d = RSC_WAIT;
            reason_d = RSC_WAIT_SOFTWARE;
          end else begin
            state_d = RSC_START;
          end
        end
      end
      RSC_WAIT: begin
        if ((reason_q == RSC_WAIT_VOLT && !cmp_q.overVolt)
            || (reason_q == RSC_WAIT_BULK && cmp_q.bulkGood)
            || (reason_q == RSC_WAIT_SKIP && !cmp_q.skipIn)
            || (reason_q == RSC_WAIT_SOFTWARE && permit_q)) begin
          state_d = RSC_CHARGE;
        end
      end
      RSC_START, RSC_SOFT, RSC_RUN: begin
        if (limitFault) begin
          state_d = RSC_LATCH;
        end else if (cmp_q.overload) begin
          state_d = RSC_RECOVER;
        end else if (cmp_q.supplyOff) begin
          state_d = RSC_OFF;
        end else if (state_q == RSC_START && phaseDone) begin
          state_d = RSC_SOFT;
        end else if (state_q == RSC_SOFT && phaseDone) begin
          state_d = RSC_RUN;
        end else if (state_q == RSC_RUN && !cmp_q.bulkGood) begin
          state_d = RSC_WAIT;
          reason_d = RSC_WAIT_BULK;
        end else if (state_q == RSC_RUN && cmp_q.skipIn) begin
          state_d = RSC_SKIP;
        end
      end
      RSC_SKIP: begin
        if (cmp_q.supplyOff) begin
          state_d = RSC_OFF;
        end else if (cmp_q.skipOut) begin
          state_d = RSC_RUN;
        end
      end
      RSC_RECOVER: begin
        if (phaseDone) begin
          state_d = RSC_CHARGE;
        end
      end
      RSC_LATCH: begin
        state_d = RSC_LATCH;
      end
      default: begin
        state_d = RSC_OFF;
      end
    endcase
    if (cmp_q.supplyReset) begin
      state_d = RSC_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= RSC_OFF;
      reason_q <= RSC_WAIT_BULK;
    end else begin
      state_q <= state_d;
      reason_q <= reason_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phaseCnt_q <= '0;
    end else if (stateChange) begin
      phaseCnt_q <= phaseLoad;
    end else if (!phaseDone) begin
      phaseCnt_q <= phaseCnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      otCnt_q <= '0;
    end else if (otStart) begin
      otCnt_q <= CW'(OT_BLANK - 1);
    end else if (otMask) begin
      otCnt_q <= otCnt_q - 1'b1;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  wire rscBias_s bias_d;
  logic gate_q;
  logic source_q;
  logic selfSupply_q;
  logic front_q;

  wire gate_d = (state_d == RSC_START) || (state_d == RSC_SOFT) || (state_d == RSC_RUN);
  wire source_d = (state_d == RSC_OFF) || (state_d == RSC_CHARGE);
  wire selfSupply_d = (state_d == RSC_WAIT) || (state_d == RSC_RECOVER)
                      || (state_d == RSC_LATCH);
  wire monitorOn_d = (state_d == RSC_CHARGE) || (state_d == RSC_BLANK)
                     || (state_d == RSC_WAIT) || gate_d;

  assign bias_d.undervoltageMonitor = monitorOn_d;
  assign bias_d.feedbackLoop = (state_d != RSC_OFF);
  assign bias_d.protect = (state_d == RSC_BLANK) || gate_d
                          || (state_d == RSC_WAIT && reason_d != RSC_WAIT_BULK);
  assign bias_d.frontStage = monitorOn_d;
  assign bias_d.core = gate_d;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      biasEnable <= '0;
      gate_q <= 1'b0;
      source_q <= 1'b0;
      selfSupply_q <= 1'b0;
      front_q <= 1'b0;
    end else begin
      biasEnable <= bias_d;
      gate_q <= gate_d;
      source_q <= source_d;
      selfSupply_q <= selfSupply_d;
      front_q <= monitorOn_d;
    end
  end

  assign gateDriveOutputs = gate_q;
  assign startupSourceOn = source_q;
  assign dynamicSelfSupply = selfSupply_q;
  assign frontStageModeOutput = front_q;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  wire hitCtrl = (paddr == CTRL_OFFSET);
  wire hitStatus = (paddr == STATUS_OFFSET);
  wire setupPhase = psel && !penable;
  wire writeTake = psel && penable && pwrite && hitCtrl;
  wire [31:0] ctrlWord = {31'h0, permit_q};
  wire [31:0] statusWord = {7'h0, cmp_q, 3'h0, gate_q, source_q, selfSupply_q, front_q,
                            biasEnable.protect, 2'h0, reason_q, state_q};
  wire [31:0] readMux = hitCtrl ? ctrlWord : (hitStatus ? statusWord : 32'h0);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      permit_q <= CTRL_PERMIT_RESET;
      prdata <= 32'h0;
    end else begin
      if (writeTake) begin
        permit_q <= pwdata[CTRL_PERMIT_POS];
      end
      if (setupPhase) begin
        prdata <= readMux;
      end
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hitCtrl || hitStatus);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_blankClean;
    state_q == RSC_BLANK && phaseDone && !cmp_q.overVolt && cmp_q.bulkGood
      && !cmp_q.skipIn && permit_q && !cmp_q.supplyReset;
  endsequence

  sequence s_burstStart;
    state_q == RSC_SKIP && cmp_q.skipOut && !cmp_q.supplyOff && !cmp_q.supplyReset;
  endsequence

  property p_blankStart;
    s_blankClean |=> state_q == RSC_START ##0 gateDriveOutputs;
  endproperty
  a_blankStart: assert property (p_blankStart) else $error("no start after clean blanking");

  property p_blankVolt;
    state_q == RSC_BLANK && phaseDone && cmp_q.overVolt && !cmp_q.supplyReset
      |=> state_q == RSC_WAIT && !gateDriveOutputs && reason_q == RSC_WAIT_VOLT;
  endproperty
  a_blankVolt: assert property (p_blankVolt) else $error("drivers not held off by overvoltage");

  property p_blankHold;
    state_q == RSC_BLANK && !phaseDone && !cmp_q.supplyReset |=> state_q == RSC_BLANK;
  endproperty
  a_blankHold: assert property (p_blankHold) else $error("fault acted during blanking");

  property p_overload;
    activeRun && cmp_q.overload && !limitFault && !cmp_q.supplyReset
      |=> state_q == RSC_RECOVER ##0 (!gateDriveOutputs && biasEnable == 5'b01000
      && dynamicSelfSupply);
  endproperty
  a_overload: assert property (p_overload) else $error("overload stop wrong");

  property p_recoverEnd;
    state_q == RSC_RECOVER && phaseDone && !cmp_q.supplyReset
      |=> state_q == RSC_CHARGE ##0 startupSourceOn;
  endproperty
  a_recoverEnd: assert property (p_recoverEnd) else $error("no recharge after recovery");

  property p_skipQuiet;
    state_q == RSC_SKIP |-> !startupSourceOn && !gateDriveOutputs
      && biasEnable == 5'b01000;
  endproperty
  a_skipQuiet: assert property (p_skipQuiet) else $error("skip mode not quiet");

  property p_burst;
    s_burstStart |=> state_q == RSC_RUN && otMask && gateDriveOutputs && !startupSourceOn;
  endproperty
  a_burst: assert property (p_burst) else $error("burst start wrong");

  property p_skipOff;
    state_q == RSC_SKIP && cmp_q.supplyOff |=> state_q == RSC_OFF;
  endproperty
  a_skipOff: assert property (p_skipOff) else $error("skip undervoltage not off");

  property p_latchHold;
    state_q == RSC_LATCH && !cmp_q.supplyReset |=> state_q == RSC_LATCH && dynamicSelfSupply;
  endproperty
  a_latchHold: assert property (p_latchHold) else $error("latch left early");

  property p_brownOut;
    state_q == RSC_RUN && !cmp_q.bulkGood && !limitFault && !cmp_q.overload
      && !cmp_q.supplyOff && !cmp_q.supplyReset
      |=> state_q == RSC_WAIT ##0 (frontStageModeOutput && !biasEnable.protect
      && !gateDriveOutputs && dynamicSelfSupply);
  endproperty
  a_brownOut: assert property (p_brownOut) else $error("brown-out handling wrong");

  property p_supplyOn;
    (state_q == RSC_OFF || state_q == RSC_CHARGE) && cmp_q.supplyOn && !cmp_q.supplyReset
      |=> state_q == RSC_BLANK ##0 (biasEnable == 5'b11110 && frontStageModeOutput);
  endproperty
  a_supplyOn: assert property (p_supplyOn) else $error("supply-on bias wrong");

  property p_syncDelay;
    $rose(cmpIn.overVolt) ##1 cmpIn.overVolt |=> cmp_q.overVolt;
  endproperty
  a_syncDelay: assert property (p_syncDelay) else $error("synchroniser delay wrong");

endmodule : rsc_sequencer

`default_nettype wire

/* File: test/rsc_plant_model.sv */
// Purpose: comparator and supply model at the far side of the sequencer
// Assumes: bench sets plug, bulk, feedback and fault levels on ctl
// Notes: supply charges only while the startup source is on and drains when unplugged
`timescale 1ns/1ps
`default_nettype none

module rsc_plant_model (
  input wire logic clk,
  input wire logic [6:0] ctl,
  input wire logic startupSourceOn,
  output var rsc_pkg::rscCmp_s cmpIn
);
  import rsc_pkg::*;

  // ----------------------------------------
  // supply capacitor
  // ----------------------------------------
  int vcc;

  initial vcc = 0;

  // holds its charge while plugged; self-supply and aux winding keep it up
  always @(posedge clk) begin
    if (!ctl[6]) begin
      vcc <= (vcc > 0) ? vcc - 1 : 0;
    end else if (startupSourceOn && vcc < 20) begin
      vcc <= vcc + 1;
    end
  end

  // ----------------------------------------
  // comparator levels
  // ----------------------------------------
  always_comb begin
    cmpIn.supplyOn = (vcc >= 15);
    cmpIn.supplyOff = (vcc < 8);
    cmpIn.supplyReset = (vcc < 3);
    cmpIn.bulkGood = ctl[5];
    cmpIn.skipIn = ctl[4];
    cmpIn.skipOut = ctl[3];
    cmpIn.overload = ctl[2];
    cmpIn.overVolt = ctl[1];
    cmpIn.overTemp = ctl[0];
  end
endmodule : rsc_plant_model

`default_nettype wire

/* File: test/resonant_controller_sequencer_test.sv */
// Purpose: self-checking bench of the resonant controller sequencer
// Assumes: short cycle parameters; apb answers whenever pready is seen
// Notes: ctl bits are plug, bulk, skip in, skip out, overload, overvolt, overtemp
`timescale 1ns/1ps
`default_nettype none

module resonant_controller_sequencer_test;
  import rsc_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int VB = 8;
  localparam int AR = 20;
  typedef struct packed {
    logic [6:0] in;
    int w;
    logic [3:0] st;
    logic [5:0] ex;
    logic [5:0] mk;
    logic [2:0] gsd;
  } rscRow_s;
  logic clk = 1'b0;
  logic reset_n;
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic gateDriveOutputs, startupSourceOn, dynamicSelfSupply, frontStageModeOutput;
  logic [6:0] ctl;
  rscCmp_s cmpIn;
  rscBias_s biasEnable;
  rscRow_s rows[20];
  int bad_count = 0;
  int check_count = 0;
  int n;
  wire logic [5:0] outs = {biasEnable, frontStageModeOutput};
  wire logic [2:0] gsd = {gateDriveOutputs, startupSourceOn, dynamicSelfSupply};

  always #4 clk = ~clk;

  rsc_sequencer #(.CW(28), .VCC_BLANK(VB), .OT_BLANK(8), .START_PHASE(6), .SOFT_START(6),
    .AUTO_RECOVERY(AR)) i_rsc_sequencer (.clk(clk), .reset_n(reset_n), .cmpIn(cmpIn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .biasEnable(biasEnable),
    .gateDriveOutputs(gateDriveOutputs), .startupSourceOn(startupSourceOn),
    .dynamicSelfSupply(dynamicSelfSupply), .frontStageModeOutput(frontStageModeOutput));

  rsc_plant_model i_rsc_plant_model (.clk(clk), .ctl(ctl), .startupSourceOn(startupSourceOn),
    .cmpIn(cmpIn));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task results;
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task chkOut(input logic [5:0] got, input logic [5:0] ex, input logic [5:0] mk);
    check_count++;
    if ((got & mk) !== (ex & mk)) begin
      bad_count++;
      $display("CHECK FAILED %0t outputs %b expected %b", $time, got, ex);
    end
  endtask : chkOut

  task chkReg(input logic [31:0] got, input logic [31:0] ex);
    check_count++;
    if (got !== ex) begin
      bad_count++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, ex);
    end
  endtask : chkReg

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // cycles until the picked output is seen: 0 self-supply, 1 source, 2 gate, 3 source low
  task countTo(input int k, output int c);
    logic [3:0] pick;
    c = 0;
    pick = {~startupSourceOn, gateDriveOutputs, startupSourceOn, dynamicSelfSupply};
    while (pick[k] !== 1'b1) begin
      @(posedge clk);
      c++;
      pick = {~startupSourceOn, gateDriveOutputs, startupSourceOn, dynamicSelfSupply};
    end
  endtask : countTo

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    rows = '{
      '{7'h60, 60, 4'h5, 6'h3E, 6'h3E, 3'h4},
      '{7'h70, 12, 4'h6, 6'h10, 6'h3E, 3'h0},
      '{7'h69, 5, 4'h5, 6'h3E, 6'h3E, 3'h4},
      '{7'h69, 12, 4'h9, 6'h10, 6'h3E, 3'h1},
      '{7'h20, 40, 4'h0, 6'h00, 6'h3F, 3'h2},
      '{7'h60, 60, 4'h5, 6'h3E, 6'h3E, 3'h4},
      '{7'h64, 8, 4'h8, 6'h10, 6'h3E, 3'h1},
      '{7'h60, 60, 4'h5, 6'h3E, 6'h3E, 3'h4},
      '{7'h62, 8, 4'h9, 6'h10, 6'h3E, 3'h1},
      '{7'h60, 12, 4'h9, 6'h10, 6'h3E, 3'h1},
      '{7'h20, 40, 4'h0, 6'h00, 6'h3F, 3'h2},
      '{7'h62, 40, 4'h7, 6'h3D, 6'h3F, 3'h1},
      '{7'h60, 40, 4'h5, 6'h3E, 6'h3E, 3'h4},
      '{7'h40, 10, 4'h7, 6'h35, 6'h3F, 3'h1},
      '{7'h60, 40, 4'h5, 6'h3E, 6'h3E, 3'h4},
      '{7'h70, 12, 4'h6, 6'h10, 6'h3E, 3'h0},
      '{7'h30, 40, 4'h0, 6'h00, 6'h3F, 3'h2},
      '{7'h40, 40, 4'h7, 6'h35, 6'h3F, 3'h1},
      '{7'h70, 40, 4'h7, 6'h3D, 6'h3F, 3'h1},
      '{7'h60, 40, 4'h5, 6'h3E, 6'h3E, 3'h4}
    };
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ctl = 7'h00;
    repeat (2) @(posedge clk);
    chkOut(outs, 6'h00, 6'h3F);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chkOut({3'h0, gsd}, 6'h02, 6'h07);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chkReg(rd, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chkReg({rd[30:0], er}, 32'h1);
    foreach (rows[i]) begin
      @(posedge clk);
      ctl <= rows[i].in;
      repeat (rows[i].w) @(posedge clk);
      chkOut(outs, rows[i].ex, rows[i].mk);
      chkOut({3'h0, gsd}, {3'h0, rows[i].gsd}, 6'h07);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chkReg({28'h0, rd[3:0]}, {28'h0, rows[i].st});
    end
    @(posedge clk);
    ctl <= 7'h64;
    countTo(0, n);
    ctl <= 7'h60;
    countTo(1, n);
    chkReg(32'(n), 32'(AR));
    countTo(3, n);
    countTo(2, n);
    chkReg(32'(n), 32'(VB));
    repeat (20) @(posedge clk);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    ctl <= 7'h64;
    repeat (8) @(posedge clk);
    ctl <= 7'h60;
    repeat (60) @(posedge clk);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chkReg({26'h0, rd[5:0]}, 32'h37);
    apb(1'b1, STATUS_OFFSET, 32'hFFFFFFFF);
    chkReg({31'h0, er}, 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    repeat (40) @(posedge clk);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chkReg({28'h0, rd[3:0]}, 32'h5);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chkOut(outs, 6'h00, 6'h3F);
    chkOut({3'h0, gsd}, 6'h00, 6'h07);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chkOut({3'h0, gsd}, 6'h02, 6'h07);
    results();
  end
endmodule : resonant_controller_sequencer_test

`default_nettype wire
